// file: dv/flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
	parameter int PULSE_NS = 200,
	parameter int RECOV_NS = 400,
	parameter int BUSY_NS = 600
) (
	// Pins from host
	input wire logic [26:0] flashAddr,
	input wire logic chipSelB,
	input wire logic outEnB,
	input wire logic writeStrobeB,
	input wire logic resetB,
	input wire logic [15:0] dataOut,
	input wire logic dataOe,
	// Pins to host
	output logic [15:0] dataIn,
	output logic readyBusyIn,
	output int ruleErr
);
	logic [15:0] mem [16];
	logic [3:0] wrIdx;
	logic busyDrv = 1'h0;
	logic tick = 1'h0;
	realtime tUp = 0;
	realtime tDn = 0;
	// Protect pin held in protect mode; supply never near lockout
	localparam logic WP_ON = 1'h1;
	localparam logic SUPPLY_OK = 1'h1;
	// unlock bypass needs the command set, which is left out
	wire logic drive = resetB && !chipSelB && !outEnB && writeStrobeB;
	initial ruleErr = 0;
	initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
	// Released bus toggles so a stale value never passes
	always #25 tick = ~tick;
	always_comb begin
		if (dataOe) dataIn = dataOut;
		else if (drive) dataIn = mem[{flashAddr[26], flashAddr[2:0]}];
		else dataIn = {8{tick, ~tick}};
	end
	// Pull-up on the shared line
	assign readyBusyIn = busyDrv ? 1'h0 : 1'h1;
	always @(negedge resetB) begin
		busyDrv = 1'h0;
		tDn = $realtime;
	end
	// Pulse measured from the fall, not from the previous rise
	always @(posedge resetB) begin
		if ($realtime - tDn < PULSE_NS) ruleErr++;
		tUp = $realtime;
	end
	always @(negedge chipSelB) if ($realtime - tUp < RECOV_NS) ruleErr++;
	always @(negedge writeStrobeB) begin
		wrIdx = {flashAddr[26], flashAddr[2:0]};
		if (!outEnB || chipSelB) ruleErr++;
	end
	always @(posedge writeStrobeB) if (resetB && !chipSelB) begin
		// Lowest slot stays locked while protect is on
		if (SUPPLY_OK && !(WP_ON && wrIdx == 4'h0)) mem[wrIdx] = dataIn;
		busyDrv = 1'h1;
		#BUSY_NS busyDrv = 1'h0;
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import nor_host_pkg::*;
	localparam int PULSE = 4;
	localparam int RECOV = 8;
	typedef struct packed {logic [26:0] addr; logic [15:0] data; logic [15:0] exp;} row_t;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	host_req_t req = '0;
	logic reqValid = 1'h0;
	logic flashReset = 1'h0;
	logic reqReady, rdValid, flashBusy, chipSelB, outEnB, writeStrobeB, resetB, dataOe, readyBusyIn;
	logic [15:0] rdData, dataIn, dataOut;
	logic [26:0] flashAddr;
	int ruleErr;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	// Last row hits the protected lowest slot, so the erased word stays
	row_t rows [4] = '{'{27'h0000003, 16'h1234, 16'h1234}, '{27'h4000003, 16'hABCD, 16'hABCD},
		'{27'h7FFFFFF, 16'h0F0F, 16'h0F0F}, '{27'h0000000, 16'h0000, 16'hFFFF}};
	always #25 clk = ~clk;
	nor_flash_host #(.RESET_PULSE_CYC(PULSE), .RECOVER_CYC(RECOV)) DUT (.clk(clk), .rst_b(rst_b), .req(req),
		.reqValid(reqValid), .reqReady(reqReady), .flashReset(flashReset), .rdData(rdData), .rdValid(rdValid),
		.flashBusy(flashBusy), .flashAddr(flashAddr), .chipSelB(chipSelB), .outEnB(outEnB),
		.writeStrobeB(writeStrobeB), .resetB(resetB), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.readyBusyIn(readyBusyIn));
	flash_model #(.PULSE_NS(PULSE * 50), .RECOV_NS(RECOV * 50)) model (.flashAddr(flashAddr), .chipSelB(chipSelB),
		.outEnB(outEnB), .writeStrobeB(writeStrobeB), .resetB(resetB), .dataOut(dataOut), .dataOe(dataOe),
		.dataIn(dataIn), .readyBusyIn(readyBusyIn), .ruleErr(ruleErr));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		check("model_flags", ruleErr, 0);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Request held until taken
	task automatic access(input logic wr, input logic [26:0] a, input logic [15:0] d);
		req <= '{addr: a, data: d, write: wr};
		reqValid <= 1'h1;
		@(posedge clk);
		while (reqReady !== 1'h1) @(posedge clk);
		reqValid <= 1'h0;
	endtask
	task automatic rd(input logic [26:0] a, input logic [15:0] exp);
		access(1'h0, a, 16'h0000);
		@(posedge clk);
		while (rdValid !== 1'h1) @(posedge clk);
		check("rdData", rdData, exp);
	endtask
	// Pulse and recovery both counted, requests stalled
	task automatic reset_seq();
		// Count every edge that still sees the pin low
		n = 0;
		while (resetB !== 1'h1) begin
			n++;
			@(posedge clk);
		end
		check("pulse_len", n >= PULSE, 1);
		n = 0;
		while (reqReady !== 1'h1) begin
			@(posedge clk);
			n++;
			check("standby", {chipSelB, dataOe}, 2'h2);
		end
		check("recover_len", n >= RECOV, 1);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		reset_seq();
		rd(27'h0000005, 16'hFFFF);
		foreach (rows[i]) begin
			access(1'h1, rows[i].addr, rows[i].data);
			repeat (8) @(posedge clk);
			check("busy", flashBusy, 1);
			repeat (20) @(posedge clk);
			check("idle", flashBusy, 0);
		end
		foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
		flashReset <= 1'h1;
		@(posedge clk);
		flashReset <= 1'h0;
		@(posedge clk);
		check("reset_pin", resetB, 0);
		reset_seq();
		rd(rows[1].addr, rows[1].data);
		wrap_up();
	end
endmodule
`default_nettype wire

// file: rtl/nor_flash_host.sv
// Notes on behaviour
// - Address valid at strobe fall, data at rise
// - Hold reset low for minimum pulse
// - Wait both recovery delays after reset
// - Low shared busy line: some device busy
// - Output enable high during every write
`timescale 1ns/100ps
`default_nettype none
`include "nor_host_regs.svh"
module nor_flash_host
	import nor_host_pkg::*;
#(
	parameter int RESET_PULSE_CYC = `NS_CYC_UP(`RESET_PULSE_MIN_NS),
	parameter int RECOVER_CYC = `NS_CYC_UP((`RESET_TO_READ_DELAY_NS > `RESET_TO_WRITE_DELAY_NS) ?
		`RESET_TO_READ_DELAY_NS : `RESET_TO_WRITE_DELAY_NS),
	parameter int READ_CYC = `NS_CYC_UP(`READ_ACCESS_NS),
	parameter int STROBE_CYC = `NS_CYC_UP(`WRITE_PULSE_NS),
	parameter int SETUP_CYC = `NS_CYC_UP(`SETUP_NS)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// User request
	input wire nor_host_pkg::host_req_t req,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic flashReset,
	// User answer
	output logic [15:0] rdData,
	output logic rdValid,
	output logic flashBusy,
	// Flash pins
	output logic [26:0] flashAddr,
	output logic chipSelB,
	output logic outEnB,
	output logic writeStrobeB,
	output logic resetB,
	input wire logic [15:0] dataIn,
	output logic [15:0] dataOut,
	output logic dataOe,
	input wire logic readyBusyIn
);
	import nor_host_pkg::*;

	typedef struct packed {
		host_state_t st;
		logic [`CNT_WIDTH-1:0] cnt;
		host_req_t cur;
		pin_ctl_t pin;
		logic [15:0] rd;
		logic rdv;
	} state_t;

	state_t s_r, s_nxt;
	logic [16:0] syncIn, syncOut;

	////////////////////////////////////////////////////////////
	// Pin inputs come from another timing world
	assign syncIn = {readyBusyIn, dataIn};
	nor_sync2 #(.WIDTH(17)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	function automatic logic [`CNT_WIDTH-1:0] cyc(input int n);
		cyc = `CNT_WIDTH'(n - 1);
	endfunction

	////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdv = 1'h0;
		if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - `CNT_WIDTH'(1);
		end
		case (s_r.st)
			ST_RESET: begin
				s_nxt.pin = '{chipSelB: 1'h1, outEnB: 1'h1, writeStrobeB: 1'h1, resetB: 1'h0, dataOe: 1'h0};
				if (s_r.cnt == '0) begin
					s_nxt.st = ST_RECOVER;
					s_nxt.pin.resetB = 1'h1;
					s_nxt.cnt = cyc(RECOVER_CYC);
				end
			end
			ST_RECOVER: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (reqValid) begin
					// Full address including die select bit is driven as given
					s_nxt.cur = req;
					s_nxt.st = ST_SETUP;
					s_nxt.pin.chipSelB = 1'h0;
					s_nxt.pin.outEnB = 1'h1;
					s_nxt.pin.dataOe = req.write;
					s_nxt.cnt = cyc(SETUP_CYC);
				end
			end
			ST_SETUP: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = ST_STROBE;
					if (s_r.cur.write == `CMD_WRITE) begin
						// Chip select already low, so strobe fall is the latching fall
						s_nxt.pin.writeStrobeB = 1'h0;
						s_nxt.cnt = cyc(STROBE_CYC);
					end else begin
						s_nxt.pin.outEnB = 1'h0;
						s_nxt.cnt = cyc(READ_CYC + `SYNC_STAGES); // Synchroniser delay on top of access
					end
				end
			end
			ST_STROBE: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = ST_HOLD;
					if (s_r.cur.write == `CMD_WRITE) begin
						// Strobe rises before chip select and data, so data holds
						s_nxt.pin.writeStrobeB = 1'h1;
					end else begin
						s_nxt.rd = syncOut[15:0];
						s_nxt.rdv = 1'h1;
						s_nxt.pin.outEnB = 1'h1;
					end
				end
			end
			ST_HOLD: begin
				s_nxt.st = ST_IDLE;
				s_nxt.pin.chipSelB = 1'h1;
				s_nxt.pin.dataOe = 1'h0;
			end
			default: begin
				s_nxt.st = ST_RESET;
			end
		endcase
		if (flashReset && s_r.st != ST_RESET) begin
			s_nxt.st = ST_RESET;
			s_nxt.pin = '{chipSelB: 1'h1, outEnB: 1'h1, writeStrobeB: 1'h1, resetB: 1'h0, dataOe: 1'h0};
			s_nxt.cnt = cyc(RESET_PULSE_CYC);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.st <= ST_RESET;
			s_r.cnt <= `CNT_WIDTH'(RESET_PULSE_CYC - 1);
			s_r.pin <= '{chipSelB: 1'h1, outEnB: 1'h1, writeStrobeB: 1'h1, resetB: 1'h0, dataOe: 1'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////
	assign reqReady = (s_r.st == ST_IDLE) && !flashReset;
	assign rdData = s_r.rd;
	assign rdValid = s_r.rdv;
	// Low means at least one device on the shared line is busy
	assign flashBusy = !syncOut[16];
	assign flashAddr = s_r.cur.addr;
	assign dataOut = s_r.cur.data;
	assign chipSelB = s_r.pin.chipSelB;
	assign outEnB = s_r.pin.outEnB;
	assign writeStrobeB = s_r.pin.writeStrobeB;
	assign resetB = s_r.pin.resetB;
	assign dataOe = s_r.pin.dataOe;

	////////////////////////////////////////////////////////////
	logic [`CNT_WIDTH:0] lowCnt_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_r <= '0;
		end else if (!resetB) begin
			lowCnt_r <= lowCnt_r + (`CNT_WIDTH+1)'(1);
		end else begin
			lowCnt_r <= '0;
		end
	end
	reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(resetB) |-> lowCnt_r >= (`CNT_WIDTH+1)'(RESET_PULSE_CYC))
		else $error("reset pulse too short");
	oe_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		!writeStrobeB |-> outEnB && !chipSelB)
		else $error("output enable low during write");
	bus_turn_a: assert property (@(posedge clk) disable iff (!rst_b)
		!outEnB |-> !dataOe && !chipSelB)
		else $error("bus contention on read");
	addr_stable_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(writeStrobeB) |-> $stable(flashAddr) ##1 ($stable(flashAddr) && $stable(dataOut)) [*1])
		else $error("address moved at strobe");
	data_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(writeStrobeB) |-> dataOe && !chipSelB && $stable(dataOut))
		else $error("data not held at strobe rise");
	recover_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(resetB) |-> chipSelB [*8])
		else $error("access during recovery");
	standby_a: assert property (@(posedge clk) disable iff (!rst_b)
		chipSelB |-> outEnB && writeStrobeB)
		else $error("strobe while deselected");
	read_done_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(outEnB) |-> ##[1:300] rdValid)
		else $error("read never completed");
endmodule
`default_nettype wire

// file: rtl/nor_host_pkg.sv
package nor_host_pkg;
	typedef struct packed {
		logic [26:0] addr;
		logic [15:0] data;
		logic write;
	} host_req_t;
	typedef struct packed {
		logic chipSelB;
		logic outEnB;
		logic writeStrobeB;
		logic resetB;
		logic dataOe;
	} pin_ctl_t;
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_RECOVER = 3'h1,
		ST_IDLE = 3'h2,
		ST_SETUP = 3'h3,
		ST_STROBE = 3'h4,
		ST_HOLD = 3'h5
	} host_state_t;
endpackage

// file: rtl/nor_host_regs.svh
`ifndef NOR_HOST_REGS_SVH
`define NOR_HOST_REGS_SVH
// Timing figures in ns
`define CLK_PERIOD_NS 50
`define RESET_PULSE_MIN_NS 50000
`define RESET_TO_READ_DELAY_NS 200000
`define RESET_TO_WRITE_DELAY_NS 200000
`define READ_ACCESS_NS 110
`define WRITE_PULSE_NS 50
`define SETUP_NS 50
// Read data passes the two-stage synchroniser before capture
`define SYNC_STAGES 2
`define NS_CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_WIDTH 27
`define DATA_WIDTH 16
`define CNT_WIDTH 16
`define CMD_WRITE 1'h1
`define CMD_READ 1'h0
`endif

// file: rtl/nor_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module nor_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '1;
			syncOut <= '1;
		end else begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule
`default_nettype wire
